// ===== tb/ctl_model.sv
`timescale 1ns/1ns

module ctl_model (
  input wire logic clk_sys,
  output sram_port_pkg::link_ctl_t link_ctl,
  output logic [5:0] addr,
  output logic [35:0] data_in,
  output logic [3:0] lane_mask_n
);
  // C pair runs one cycle behind K while set
  logic c_run = 1'h0;

  // ==========================================================
  // Parked bus: clocks low, C pair high so reads follow K
  initial begin
    link_ctl = '{k: 1'h0, k_n: 1'h0, c: 1'h1, c_n: 1'h1,
      read_sel_n: 1'h1, write_sel_n: 1'h1};
    addr = 6'h00;
    data_in = 36'h0_0000_0000;
    lane_mask_n = 4'hf;
  end

  // One K period of 8 cycles; inputs change mid-phase
  task automatic kcycle(input logic rd_n, input logic wr_n,
    input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
    input logic [35:0] d1, input logic [3:0] m1);
    link_ctl.read_sel_n <= rd_n;
    link_ctl.write_sel_n <= wr_n;
    addr <= a;
    data_in <= d0;
    lane_mask_n <= m0;
    repeat (2) @(posedge clk_sys);
    link_ctl.k <= 1'h1;
    link_ctl.k_n <= 1'h0;
    @(posedge clk_sys);
    // C pair trails K by one cycle when it runs
    if (c_run) begin
      link_ctl.c <= 1'h1;
      link_ctl.c_n <= 1'h0;
    end
    @(posedge clk_sys);
    link_ctl.read_sel_n <= 1'h1;
    link_ctl.write_sel_n <= 1'h1;
    addr <= ~a;
    data_in <= d1;
    lane_mask_n <= m1;
    repeat (2) @(posedge clk_sys);
    link_ctl.k <= 1'h0;
    link_ctl.k_n <= 1'h1;
    @(posedge clk_sys);
    if (c_run) begin
      link_ctl.c <= 1'h0;
      link_ctl.c_n <= 1'h1;
    end
    @(posedge clk_sys);
  endtask : kcycle

  // Start or stop the C pair; both pins park high when stopped
  task automatic c_mode(input logic on);
    c_run <= on;
    link_ctl.c <= 1'h1;
    link_ctl.c_n <= 1'h1;
  endtask : c_mode
endmodule : ctl_model

// ===== tb/quad_rate_burst2_sram_port_tb_top.sv
`timescale 1ns/1ns

module quad_rate_burst2_sram_port_tb_top;
  localparam logic [35:0] v_hi = 36'h0_0000_0001;
  localparam logic [35:0] v_lo = 36'h0_0000_0000;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic ce = 1'h1;
  sram_port_pkg::link_ctl_t link_ctl;
  logic [5:0] addr;
  logic [35:0] data_in;
  logic [3:0] lane_mask_n;
  logic [35:0] q_out;
  logic q_oe_n;
  logic echo_strobe;
  logic echo_strobe_n;
  int mismatches = 0;
  int n_compared = 0;

  // Free running 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  quad_rate_burst2_sram_port u_quad_rate_burst2_sram_port (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .link_ctl(link_ctl), .addr(addr), .data_in(data_in),
    .lane_mask_n(lane_mask_n), .q_out(q_out), .q_oe_n(q_oe_n),
    .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n)
  );

  ctl_model u_ctl_model (
    .clk_sys(clk_sys), .link_ctl(link_ctl), .addr(addr),
    .data_in(data_in), .lane_mask_n(lane_mask_n)
  );

  // ==========================================================
  // Shared helpers
  task automatic chk(input string what, input logic [35:0] exp,
    input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic nop();
    u_ctl_model.kcycle(1'h1, 1'h1, 6'h2a, v_lo, 4'hf, ~v_lo, 4'hf);
  endtask : nop

  // Wait for outputs to turn on, then check both words in turn
  task automatic watch(input logic [35:0] e0, input logic [35:0] e1);
    int n;
    n = 0;
    while (q_oe_n !== 1'h0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("oe_on", v_lo, {35'h0, q_oe_n});
    repeat (2) @(negedge clk_sys);
    chk("word0", e0, q_out);
    repeat (4) @(negedge clk_sys);
    chk("word1", e1, q_out);
    repeat (4) @(negedge clk_sys);
    chk("oe_off", v_hi, {35'h0, q_oe_n});
  endtask : watch

  task automatic rd(input logic [5:0] a, input logic [35:0] e0,
    input logic [35:0] e1);
    fork
      begin
        u_ctl_model.kcycle(1'h0, 1'h1, a, v_lo, 4'hf, ~v_lo, 4'hf);
        nop();
      end
      watch(e0, e1);
    join
    @(posedge clk_sys);
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic t_burst();
    u_ctl_model.kcycle(1'h1, 1'h0, 6'h05, 36'h1_2345_6789, 4'h0,
      36'h9_8765_4321, 4'h0);
    rd(6'h05, 36'h1_2345_6789, 36'h9_8765_4321);
    $display("test burst done");
  endtask : t_burst

  // Clear one lane per word at a time; last word1 writes nothing
  task automatic t_mask();
    logic [35:0] e0;
    logic [35:0] e1;
    logic [3:0] m1;
    e0 = 36'hf_ffff_ffff;
    e1 = 36'hf_ffff_ffff;
    u_ctl_model.kcycle(1'h1, 1'h0, 6'h09, e0, 4'h0, e1, 4'h0);
    for (int i = 0; i < 4; i++) begin
      m1 = (i == 3) ? 4'hf : 4'hf ^ (4'h1 << i);
      u_ctl_model.kcycle(1'h1, 1'h0, 6'h09, v_lo, 4'hf ^ (4'h1 << i),
        v_lo, m1);
      e0 = e0 & ~(36'h0_0000_01ff << (9 * i));
      if (i < 3) begin
        e1 = e1 & ~(36'h0_0000_01ff << (9 * i));
      end
      rd(6'h09, e0, e1);
    end
    $display("test mask done");
  endtask : t_mask

  // Write burst starts while the read burst is still going out
  task automatic t_overlap();
    fork
      begin
        u_ctl_model.kcycle(1'h0, 1'h1, 6'h09, v_lo, 4'hf, v_lo, 4'hf);
        u_ctl_model.kcycle(1'h1, 1'h0, 6'h05, 36'ha_aaaa_aaaa, 4'h0,
          36'h5_5555_5555, 4'h0);
        nop();
      end
      watch(v_lo, 36'hf_f800_0000);
    join
    @(posedge clk_sys);
    rd(6'h05, 36'ha_aaaa_aaaa, 36'h5_5555_5555);
    $display("test overlap done");
  endtask : t_overlap

  // Idle K periods: outputs stay off, echo keeps toggling
  task automatic t_nop();
    int rises;
    int bad;
    logic prev;
    rises = 0;
    bad = 0;
    prev = echo_strobe;
    fork
      begin
        nop();
        nop();
      end
      repeat (16) begin
        @(negedge clk_sys);
        if (echo_strobe === 1'h1 && prev === 1'h0) rises++;
        if (q_oe_n !== 1'h1 || echo_strobe_n !== ~echo_strobe) bad++;
        prev = echo_strobe;
      end
    join
    chk("echo_rises", 36'h0_0000_0002, 36'(rises));
    chk("idle_bad", v_lo, 36'(bad));
    @(posedge clk_sys);
    $display("test nop done");
  endtask : t_nop

  // Enable low with the link stopped: pending word waits, then goes out
  task automatic t_freeze();
    u_ctl_model.kcycle(1'h0, 1'h1, 6'h05, v_lo, 4'hf, v_lo, 4'hf);
    ce <= 1'h0;
    repeat (12) @(negedge clk_sys);
    chk("frozen_oe", v_hi, {35'h0, q_oe_n});
    @(posedge clk_sys);
    ce <= 1'h1;
    fork
      nop();
      watch(36'ha_aaaa_aaaa, 36'h5_5555_5555);
    join
    @(posedge clk_sys);
    $display("test freeze done");
  endtask : t_freeze

  // C pair running one cycle behind K: output timing follows C
  task automatic t_cmode();
    u_ctl_model.c_mode(1'h1);
    nop();
    fork
      begin
        u_ctl_model.kcycle(1'h0, 1'h1, 6'h05, v_lo, 4'hf, ~v_lo, 4'hf);
        nop();
      end
      watch(36'ha_aaaa_aaaa, 36'h5_5555_5555);
      begin
        repeat (6) @(negedge clk_sys);
        chk("echo_k_time", v_lo, {35'h0, echo_strobe});
        @(negedge clk_sys);
        chk("echo_c_time", v_hi, {35'h0, echo_strobe});
      end
    join
    @(posedge clk_sys);
    u_ctl_model.c_mode(1'h0);
    $display("test cmode done");
  endtask : t_cmode

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Main sequence: reset, idle two K periods, then scenarios
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (16) @(posedge clk_sys);
    chk("oe_reset", v_hi, {35'h0, q_oe_n});
    chk("echo_reset", v_hi, {35'h0, echo_strobe_n});
    $display("test reset done");
    t_burst();
    t_mask();
    t_overlap();
    t_nop();
    t_freeze();
    t_cmode();
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end
endmodule : quad_rate_burst2_sram_port_tb_top

// ===== verilog/pin_sync.sv
`timescale 1ns/1ns

module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  // ==========================================================
  // Two stages; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // Shift one stage per enabled cycle
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.meta = pin_in;
      st_next.held = st_reg.meta;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.held;

endmodule : pin_sync

// ===== verilog/quad_rate_burst2_sram_port.sv
// How it works
// - Write select low at K rise loads address; words taken at K then K_n.
// - Read select low at K rise loads address; words out on next out clocks.
// - Both selects high: no new burst loads; data outputs stay released unless an earlier read burst is still going out.
// - Selects are sampled only at the K rising edge; K paces writes, the output clock pair paces reads.
// - Write words are captured on both K and K_n rising edges.
// - Read data follows C pair, or the K pair when both C pins sit high.
// - Burst address gets a low bit: offset zero first, offset one second.
// - Every burst ends after exactly two word transfers.
// - Read and write sequencers are independent and may overlap.
// - Each active-low lane mask gates one 9-bit lane; all ones writes nothing.
// - Lane masks are sampled anew for each word of a write burst.
// - Data outputs are released from reset until a read is served.
// - Stopped clocks leave all state as it was.
// - Echo strobes follow the output clock continuously, even when released.
`timescale 1ns/1ns
`include "sram_port_defs.svh"

module quad_rate_burst2_sram_port #(
  parameter int ADDR_W = `ADDR_W,
  parameter int LANES = `LANES,
  parameter int LANE_W = `LANE_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input sram_port_pkg::link_ctl_t link_ctl,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES*LANE_W-1:0] data_in,
  input wire logic [LANES-1:0] lane_mask_n,
  output logic [LANES*LANE_W-1:0] q_out,
  output logic q_oe_n,
  output logic echo_strobe,
  output logic echo_strobe_n
);

  localparam int DW = LANES * LANE_W;
  localparam int CW = $bits(sram_port_pkg::link_ctl_t);
  localparam int SW = CW + ADDR_W + DW + LANES;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  // ==========================================================
  // Pin synchronisation, all pins through one aligned pipe
  sram_port_pkg::link_ctl_t ctl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DW-1:0] data_s;
  logic [LANES-1:0] mask_s;
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;

  assign pins_raw = {link_ctl, addr, data_in, lane_mask_n};

  pin_sync #(
    .W(SW)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pin_in(pins_raw),
    .pin_out(pins_s)
  );

  assign {ctl_s, addr_s, data_s, mask_s} = pins_s;

  // ==========================================================
  // Block state
  typedef struct packed {
    sram_port_pkg::link_ctl_t prev;
    sram_port_pkg::rd_state_t rd_state;
    logic rd_pend;
    logic [ADDR_W-1:0] raddr;
    logic [ADDR_W-1:0] raddr_live;
    logic wr_pend;
    logic [ADDR_W-1:0] waddr;
    logic [DW-1:0] q;
    logic q_oe_n;
    logic echo;
    logic echo_n;
  } port_state_t;

  localparam port_state_t RESET_ST = '{
    prev: '0,
    rd_state: sram_port_pkg::RD_IDLE,
    rd_pend: 1'b0,
    raddr: '0,
    raddr_live: '0,
    wr_pend: 1'b0,
    waddr: '0,
    q: '0,
    q_oe_n: `Q_OE_N_RST,
    echo: `ECHO_RST,
    echo_n: `ECHO_N_RST
  };

  port_state_t st_reg;
  port_state_t st_next;

  // ==========================================================
  // Edge detection on synchronised clock pins
  logic k_rise;
  logic kn_rise;
  logic use_k;
  logic out_rise;
  logic out_n_rise;

  assign k_rise = ctl_s.k & ~st_reg.prev.k;
  assign kn_rise = ctl_s.k_n & ~st_reg.prev.k_n;
  // Both C pins high selects the K pair for output timing
  assign use_k = ctl_s.c & ctl_s.c_n;
  assign out_rise = use_k ? k_rise : (ctl_s.c & ~st_reg.prev.c);
  assign out_n_rise = use_k ? kn_rise : (ctl_s.c_n & ~st_reg.prev.c_n);

  // ==========================================================
  // Storage array
  logic [LANES-1:0] wr_en;
  logic [ADDR_W:0] wr_idx;
  logic [ADDR_W:0] rd_idx;
  logic [DW-1:0] rd_word;

  // Read index: offset one for the second word of the live burst
  always_comb begin
    if (st_reg.rd_state == sram_port_pkg::RD_SECOND) begin
      rd_idx = {st_reg.raddr_live, `BURST_OFS1};
    end else begin
      rd_idx = {st_reg.raddr, `BURST_OFS0};
    end
  end

  // One bank per lane, so each lane has a single writing process
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LANE_W-1:0] bank [DEPTH];
    always_ff @(posedge clk_sys) begin
      if (ce && wr_en[i]) begin
        bank[wr_idx] <= data_s[i*LANE_W +: LANE_W];
      end
    end
    // Read side of this lane
    assign rd_word[i*LANE_W +: LANE_W] = bank[rd_idx];
  end

  // ==========================================================
  // Write sequencer
  always_comb begin
    wr_en = '0;
    wr_idx = '0;
    if (k_rise && !ctl_s.write_sel_n) begin
      // First word at K, masks sampled now
      wr_en = ~mask_s;
      wr_idx = {addr_s, `BURST_OFS0};
    end else if (kn_rise && st_reg.wr_pend) begin
      // Second word at K_n, masks sampled again
      wr_en = ~mask_s;
      wr_idx = {st_reg.waddr, `BURST_OFS1};
    end
  end

  // ==========================================================
  // Read sequencer, echo strobes and write burst tracking
  always_comb begin
    st_next = st_reg;
    st_next.prev = ctl_s;
    // Write burst: load at K, end after the K_n word
    if (k_rise && !ctl_s.write_sel_n) begin
      st_next.waddr = addr_s;
      st_next.wr_pend = 1'b1;
    end else if (kn_rise && st_reg.wr_pend) begin
      st_next.wr_pend = 1'b0;
    end
    // Output word launch
    case (st_reg.rd_state)
      sram_port_pkg::RD_IDLE, sram_port_pkg::RD_TAIL: begin
        if (out_n_rise) begin
          if (st_reg.rd_pend) begin
            st_next.q = rd_word;
            st_next.q_oe_n = 1'b0;
            st_next.raddr_live = st_reg.raddr;
            st_next.rd_pend = 1'b0;
            st_next.rd_state = sram_port_pkg::RD_SECOND;
          end else begin
            st_next.q_oe_n = 1'b1;
            st_next.rd_state = sram_port_pkg::RD_IDLE;
          end
        end
      end
      sram_port_pkg::RD_SECOND: begin
        if (out_rise) begin
          st_next.q = rd_word;
          st_next.rd_state = sram_port_pkg::RD_TAIL;
        end
      end
      default: begin
        st_next.q_oe_n = 1'b1;
        st_next.rd_state = sram_port_pkg::RD_IDLE;
      end
    endcase
    // Read load after launch, so a new command wins over the clear
    if (k_rise && !ctl_s.read_sel_n) begin
      st_next.rd_pend = 1'b1;
      st_next.raddr = addr_s;
    end
    // Free-running echo of the output clock pair
    if (out_rise) begin
      st_next.echo = 1'b1;
      st_next.echo_n = 1'b0;
    end else if (out_n_rise) begin
      st_next.echo = 1'b0;
      st_next.echo_n = 1'b1;
    end
  end

  // State register; clock enable low or idle pins hold all state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= RESET_ST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Pins straight from the state register
  assign q_out = st_reg.q;
  assign q_oe_n = st_reg.q_oe_n;
  assign echo_strobe = st_reg.echo;
  assign echo_strobe_n = st_reg.echo_n;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  AST_WR_LOAD: assert property (
    ce && k_rise && !ctl_s.write_sel_n
    |-> wr_idx == {addr_s, 1'b0} ##1 st_reg.wr_pend
  ) else $error("write load missed");

  AST_RD_LOAD: assert property (
    ce && k_rise && !ctl_s.read_sel_n
    |=> st_reg.rd_pend && st_reg.raddr == $past(addr_s)
  ) else $error("read load missed");

  AST_NOP_REL: assert property (
    st_reg.rd_state == sram_port_pkg::RD_IDLE |-> q_oe_n
  ) else $error("data driven while idle");

  AST_SEL_ONLY_K: assert property (
    ce && !k_rise && !out_n_rise |=> $stable(st_reg.rd_pend)
  ) else $error("read pending changed off K");

  AST_WR_SECOND: assert property (
    ce && kn_rise && st_reg.wr_pend && !k_rise
    |-> wr_en == ~mask_s && wr_idx == {st_reg.waddr, 1'b1}
  ) else $error("second write word wrong");

  AST_OUT_SEL: assert property (
    ce && use_k && k_rise |=> echo_strobe && !echo_strobe_n
  ) else $error("K pair not used for output");

  AST_FIRST_WORD: assert property (
    ce && out_n_rise && st_reg.rd_pend
    && st_reg.rd_state != sram_port_pkg::RD_SECOND
    |=> !q_oe_n && q_out == $past(rd_word)
        && st_reg.rd_state == sram_port_pkg::RD_SECOND
  ) else $error("first read word wrong");

  AST_BURST_END: assert property (
    st_reg.rd_state == sram_port_pkg::RD_SECOND && ce && out_rise
    |=> st_reg.rd_state == sram_port_pkg::RD_TAIL
        && q_out == $past(rd_word) && !q_oe_n
  ) else $error("second read word wrong");

  AST_BOTH_SM: assert property (
    ce && k_rise && !ctl_s.read_sel_n && !ctl_s.write_sel_n
    |=> st_reg.rd_pend && st_reg.wr_pend
  ) else $error("read and write not concurrent");

  AST_FREEZE: assert property (
    !ce |=> $stable(st_reg)
  ) else $error("state moved while frozen");

  AST_ECHO_PAIR: assert property (
    echo_strobe != echo_strobe_n
  ) else $error("echo strobes not complementary");

  COV_WRITE: cover property (
    ce && k_rise && !ctl_s.write_sel_n ##[1:40] ce && kn_rise
  );

  COV_READ: cover property (
    st_reg.rd_state == sram_port_pkg::RD_SECOND
    ##[1:40] st_reg.rd_state == sram_port_pkg::RD_TAIL
  );

  COV_OVERLAP: cover property (
    st_reg.wr_pend && st_reg.rd_state != sram_port_pkg::RD_IDLE
  );

  COV_K_OUT: cover property (use_k && !q_oe_n);

endmodule : quad_rate_burst2_sram_port

// ===== verilog/sram_port_defs.svh
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// ==========================================================
// Lane geometry
`define LANE_W 9
`define LANES 4

// ==========================================================
// Array depth, address bits per burst pair
`define ADDR_W 6

// ==========================================================
// Burst layout: two words, fixed order
`define BURST_LEN 2
`define BURST_OFS0 1'b0
`define BURST_OFS1 1'b1

// ==========================================================
// Reset values of the pins
`define Q_OE_N_RST 1'b1
`define ECHO_RST 1'b0
`define ECHO_N_RST 1'b1

`endif

// ===== verilog/sram_port_pkg.sv
package sram_port_pkg;

  // ==========================================================
  // Read burst sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_SECOND = 2'b01,
    RD_TAIL = 2'b10
  } rd_state_t;

  // ==========================================================
  // Clock pairs and selects from the memory controller
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic read_sel_n;
    logic write_sel_n;
  } link_ctl_t;

endpackage : sram_port_pkg
